// ==== rtl/dio_pkg.sv ====
// Contract
// - output image byte 0 bits 0..7 drive channels 1..8
// - output image byte 1 bits 0..7 drive channels 9..16
// - input image bytes 0..3 carry the 32-bit status word
// - input image byte 4 reports channels 1..8, channel 1 in bit 0
// - input image byte 5 reports channels 9..16, channel 9 in bit 0
// - status bits: 0 short, 1 output overload, 4 supply overload, 5 undervoltage
// - config byte 0 substitute mode: 0 low, 1 high, 2 hold, 3 pattern
// - config bytes 1..2 substitute pattern, used only in pattern mode
// - no direction parameters; channel direction follows use; the code drives all 16 channels in low, high and pattern substitution
// - driven outputs are echoed into the input image
// - connection requests accepted within 350 ms of power-up
// - cyclic exchange possible within 500 ms of power-up
// - only exclusive-owner connections update the outputs
package dio_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CONN_READY_MS = 350;
    localparam int unsigned XCHG_READY_MS = 500;
    localparam int unsigned CONN_READY_CYC = CLK_HZ / 1000 * CONN_READY_MS;
    localparam int unsigned XCHG_READY_CYC = CLK_HZ / 1000 * XCHG_READY_MS;
    localparam int CNT_W = 23;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] A_OUT_IMG = 8'h00;
    localparam logic [7:0] A_IN_STAT = 8'h04;
    localparam logic [7:0] A_IN_DATA = 8'h08;
    localparam logic [7:0] A_CFG = 8'h0c;
    localparam logic [7:0] A_CONN = 8'h10;
    localparam logic [7:0] A_IRQ_STAT = 8'h14;
    localparam logic [7:0] A_IRQ_MASK = 8'h18;
    localparam logic [7:0] A_READY = 8'h1c;

    localparam int B_SHORT = 0;
    localparam int B_OVLD = 1;
    localparam int B_SUP_OVLD = 4;
    localparam int B_UNDERV = 5;
    localparam logic [31:0] STAT_MASK = 32'h0000_0033;

    localparam logic [1:0] CONN_NONE = 2'h0;
    localparam logic [1:0] CONN_EXCL = 2'h1;
    localparam logic [1:0] CONN_INONLY = 2'h2;
    localparam logic [1:0] CONN_LISTEN = 2'h3;

    localparam logic [7:0] SUB_LOW = 8'h00;
    localparam logic [7:0] SUB_HIGH = 8'h01;
    localparam logic [7:0] SUB_HOLD = 8'h02;
    localparam logic [7:0] SUB_PAT = 8'h03;

    // irq bits: 0 conn ready, 1 exchange ready, 2 fault, 3 conn lost
    localparam int I_CREADY = 0;
    localparam int I_XREADY = 1;
    localparam int I_FAULT = 2;
    localparam int I_LOST = 3;
    localparam int IRQ_W = 4;

    typedef struct packed {
        logic [7:0] mode;
        logic [15:0] pattern;
    } dio_cfg_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [15:0] out_img;
        logic out_valid;
        logic [1:0] conn;
        dio_cfg_t cfg;
        logic [15:0] drive;
        logic [15:0] last;
        logic [15:0] used;
        logic [15:0] in_s1;
        logic [15:0] in_s2;
        logic [3:0] flt_s1;
        logic [3:0] flt_s2;
        logic [31:0] status;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic [CNT_W-1:0] cnt;
        logic conn_ready;
        logic xchg_ready;
    } dio_state_t;
endpackage

// ==== rtl/dio_process_image.sv ====
`timescale 1ns/100ps
`default_nettype none
module dio_process_image (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] pin_in,
    input wire logic flt_out_short,
    input wire logic flt_out_ovld,
    input wire logic flt_sup_ovld,
    input wire logic flt_sup_underv,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic conn_ready,
    output logic xchg_ready,
    output logic irq
);
    import dio_pkg::*;

    dio_state_t r;
    dio_state_t n;

    function automatic logic [15:0] subst(input dio_cfg_t c,
                                          input logic [15:0] last);
        case (c.mode)
            SUB_LOW: subst = 16'h0000;
            SUB_HIGH: subst = 16'hffff;
            SUB_HOLD: subst = last;
            SUB_PAT: subst = c.pattern;
            default: subst = 16'h0000;
        endcase
    endfunction

    // write refusal is decided in the setup cycle, so that pslverr already
    // stands in the access cycle in which the master samples it
    function automatic logic wr_err(input logic [7:0] a,
                                    input logic [7:0] mode,
                                    input logic ready);
        case (a)
            A_OUT_IMG, A_IN_STAT, A_IN_DATA: wr_err = 1'b0;
            A_IRQ_STAT, A_IRQ_MASK, A_READY: wr_err = 1'b0;
            A_CFG: wr_err = (mode > SUB_PAT);
            A_CONN: wr_err = !ready;
            default: wr_err = 1'b1;
        endcase
    endfunction

    logic wr;
    logic rd;
    logic [IRQ_W-1:0] ev;
    logic [15:0] echo;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    always_comb begin
        n = r;
        ev = '0;
        n.pready = psel && !penable;
        n.pslverr = 1'b0;
        // ------------------------------------------------------------
        // input synchronisers
        // ------------------------------------------------------------
        n.in_s1 = pin_in;
        n.in_s2 = r.in_s1;
        n.flt_s1 = {flt_sup_underv, flt_sup_ovld, flt_out_ovld,
                    flt_out_short};
        n.flt_s2 = r.flt_s1;
        n.status = '0;
        n.status[B_SHORT] = r.flt_s2[0];
        n.status[B_OVLD] = r.flt_s2[1];
        n.status[B_SUP_OVLD] = r.flt_s2[2];
        n.status[B_UNDERV] = r.flt_s2[3];
        if ((r.flt_s2 != 4'h0) && (r.status[5:0] != n.status[5:0])) begin
            ev[I_FAULT] = 1'b1;
        end
        // ------------------------------------------------------------
        // power-up readiness
        // ------------------------------------------------------------
        if (!r.xchg_ready) begin
            n.cnt = r.cnt + 1'b1;
        end
        if (r.cnt == CNT_W'(CONN_READY_CYC - 1) && !r.conn_ready) begin
            n.conn_ready = 1'b1;
            ev[I_CREADY] = 1'b1;
        end
        if (r.cnt == CNT_W'(XCHG_READY_CYC - 1)) begin
            n.xchg_ready = 1'b1;
            ev[I_XREADY] = 1'b1;
        end
        // ------------------------------------------------------------
        // register writes
        // ------------------------------------------------------------
        if (wr) begin
            case (paddr)
                A_OUT_IMG: begin
                    if (r.conn == CONN_EXCL && r.xchg_ready) begin
                        n.out_img = pwdata[15:0];
                        n.out_valid = 1'b1;
                        n.used = r.used | pwdata[15:0];
                    end
                end
                A_CFG: begin
                    n.cfg.mode = pwdata[7:0];
                    n.cfg.pattern = pwdata[23:8];
                    if (pwdata[7:0] > SUB_PAT) begin
                        n.cfg.mode = r.cfg.mode;
                        n.pslverr = 1'b1;
                    end
                end
                A_CONN: begin
                    if (!r.conn_ready) begin
                        n.pslverr = 1'b1;
                    end else begin
                        n.conn = pwdata[1:0];
                        if (pwdata[1:0] != CONN_EXCL) begin
                            n.out_valid = 1'b0;
                        end
                        if (r.conn == CONN_EXCL && pwdata[1:0] != CONN_EXCL) begin
                            ev[I_LOST] = 1'b1;
                        end
                    end
                end
                A_IRQ_STAT: n.irq_stat = r.irq_stat & ~pwdata[IRQ_W-1:0];
                A_IRQ_MASK: n.irq_mask = pwdata[IRQ_W-1:0];
                A_IN_STAT, A_IN_DATA, A_READY: ;
                default: n.pslverr = 1'b1;
            endcase
        end
        // set beats clear
        n.irq_stat = n.irq_stat | ev;
        n.irq = |(n.irq_stat & r.irq_mask);
        // ------------------------------------------------------------
        // output drive
        // ------------------------------------------------------------
        if (r.out_valid) begin
            n.drive = r.out_img;
            n.last = r.out_img;
        end else begin
            n.drive = subst(r.cfg, r.last);
            n.used = (r.cfg.mode == SUB_HOLD) ? r.used : 16'hffff;
        end
        echo = (r.used & r.drive) | (~r.used & r.in_s2);
        // ------------------------------------------------------------
        // register reads
        // ------------------------------------------------------------
        n.prdata = '0;
        if (rd) begin
            case (paddr)
                A_OUT_IMG: n.prdata = {16'h0000, r.out_img};
                A_IN_STAT: n.prdata = r.status & STAT_MASK;
                A_IN_DATA: n.prdata = {16'h0000, echo};
                A_CFG: n.prdata = {8'h00, r.cfg.pattern, r.cfg.mode};
                A_CONN: n.prdata = {30'h0, r.conn};
                A_IRQ_STAT: n.prdata = {28'h0, r.irq_stat};
                A_IRQ_MASK: n.prdata = {28'h0, r.irq_mask};
                A_READY: n.prdata = {30'h0, r.xchg_ready, r.conn_ready};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (!(psel && !penable)) begin
            n.prdata = r.prdata;
            n.pslverr = r.pslverr;
        end
        if (psel && !penable && pwrite) begin
            n.pslverr = wr_err(paddr, pwdata[7:0], r.conn_ready);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign pin_out = r.drive;
    assign pin_oe = r.used;
    assign conn_ready = r.conn_ready;
    assign xchg_ready = r.xchg_ready;
    assign irq = r.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_OUT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
        r.out_valid |=> pin_out == $past(r.out_img))
        else $error("outputs do not follow output image");
    AST_SUB_LOW: assert property (@(posedge pclk) disable iff (!presetn)
        !r.out_valid && r.cfg.mode == SUB_LOW
        |=> pin_out == 16'h0000)
        else $error("low substitute not applied");
    AST_STAT_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        (r.status & ~STAT_MASK) == 32'h0)
        else $error("reserved status bit set");
    AST_STAT_MAP: assert property (@(posedge pclk) disable iff (!presetn)
        r.status[B_UNDERV] == $past(r.flt_s2[3]))
        else $error("undervoltage not mapped to bit 5");
    AST_SUB_PAT: assert property (@(posedge pclk) disable iff (!presetn)
        !r.out_valid && r.cfg.mode == SUB_PAT
        |=> pin_out == $past(r.cfg.pattern))
        else $error("pattern substitute wrong");
    AST_SUB_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !r.out_valid && r.cfg.mode == SUB_HOLD
        |=> pin_out == $past(r.last))
        else $error("hold substitute wrong");
    AST_NONOWNER: assert property (@(posedge pclk) disable iff (!presetn)
        r.conn != CONN_EXCL |=> !r.out_valid || $past(wr))
        else $error("non-owner connection drove outputs");
    AST_CREADY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.conn_ready) |-> $past(r.cnt) == CNT_W'(CONN_READY_CYC - 1))
        else $error("connection ready at wrong time");
    AST_XREADY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(r.xchg_ready) |-> r.conn_ready)
        else $error("exchange ready before connection ready");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        r.irq |-> $past(|(r.irq_stat | ev)))
        else $error("irq without status");
endmodule
`default_nettype wire

// ==== bench/dio_field_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module dio_field_model (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] sense,
    output logic [15:0] pin_in
);
    // a driven channel reads back its own drive, like a real pin;
    // sensors only reach channels the device leaves undriven
    // readback, no contention
    always_comb begin
        pin_in = (pin_out & pin_oe) | (sense & ~pin_oe);
    end
endmodule
`default_nettype wire

// ==== bench/tb_dio_process_image.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_dio_process_image;
    import dio_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] flt = 4'h0;
    logic [15:0] sense = 16'h5a3c;
    logic [15:0] pin_in, pin_out, pin_oe, exp_d;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, conn_ready, xchg_ready, irq;
    logic [7:0] modes [4] = '{SUB_HOLD, SUB_LOW, SUB_HIGH, SUB_PAT};
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #50 pclk = ~pclk;

    dio_process_image u_dio_process_image (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pin_in(pin_in), .flt_out_short(flt[0]),
        .flt_out_ovld(flt[1]), .flt_sup_ovld(flt[2]),
        .flt_sup_underv(flt[3]), .pin_out(pin_out), .pin_oe(pin_oe),
        .conn_ready(conn_ready), .xchg_ready(xchg_ready), .irq(irq));
    dio_field_model u_dio_field_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .sense(sense), .pin_in(pin_in));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // pready, prdata and pslverr are read at the rising edge itself,
    // before the slave's registers move on that edge
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] sub_drive(input logic [7:0] m, input logic [15:0] p);
        case (m)
            SUB_HIGH: return 16'hffff;
            SUB_PAT: return p;
            default: return 16'h0000;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // tests; readiness takes millions of cycles, so all run before it
    // ----------------------------------------------------------------
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, A_READY, 32'h0);
        chk("ready", rd, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        xfer(1'b1, A_CONN, 32'(CONN_EXCL));
        chk("early conn err", 32'(err), 32'h1);
        xfer(1'b1, A_OUT_IMG, 32'h0000_abcd);
        repeat (3) @(posedge pclk);
        chk("out ignored", 32'(pin_out), 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, A_CFG, {8'h00, 16'h8001, modes[i]});
            repeat (3) @(posedge pclk);
            exp_d = sub_drive(modes[i], 16'h8001);
            chk("drive", 32'(pin_out), 32'(exp_d));
            chk("oe", 32'(pin_oe), 32'h0000_ffff);
            xfer(1'b0, A_IN_DATA, 32'h0);
            chk("in image", rd, 32'(exp_d));
        end
        xfer(1'b1, A_CFG, 32'h0000_0004);
        chk("bad mode err", 32'(err), 32'h1);
        xfer(1'b0, A_CFG, 32'h0);
        chk("mode kept", rd & 32'h00ff_ffff, 32'h0000_0003);
        for (int b = 0; b < 4; b++) begin
            flt <= 4'(1 << b);
            repeat (4) @(posedge pclk);
            xfer(1'b0, A_IN_STAT, 32'h0);
            chk("status", rd, 32'h1 << ((b < 2) ? b : b + 2));
        end
        flt <= 4'h0;
        repeat (4) @(posedge pclk);
        xfer(1'b0, A_IRQ_STAT, 32'h0);
        chk("fault event", rd & 32'h4, 32'h4);
        chk("irq masked", 32'(irq), 32'h0);
        xfer(1'b1, A_IRQ_MASK, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq on", 32'(irq), 32'h1);
        xfer(1'b1, A_IRQ_STAT, 32'h4);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'(irq), 32'h0);
        xfer(1'b0, A_IRQ_STAT, 32'h0);
        chk("w1c", rd & 32'h4, 32'h0);
        end_sim();
    end
endmodule
`default_nettype wire
